// ==== rtl/anxr_latch_bit.sv ====
// Latching-high status bit with read-to-clear and re-evaluation
`timescale 1ns/100ps
module anxr_latch_bit (
    input wire logic mclk,
    input wire logic srst,
    input wire logic setEvt,
    input wire logic readClr,
    output logic latched
);
    logic latch_q;
    logic latch_d;

    always_comb begin
        // Set beats clear: an event in the read cycle is held for the next read
        if (setEvt) begin
            latch_d = 1'b1;
        end else if (readClr) begin
            latch_d = 1'b0;
        end else begin
            latch_d = latch_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            latch_q <= 1'b0;
        end else begin
            latch_q <= latch_d;
        end
    end

    assign latched = latch_q;
endmodule : anxr_latch_bit

// ==== rtl/anxr_pkg.sv ====
// Package: register map, field layout, reset values and carriers for the expansion/next-page registers
//
// Contract
// - Expansion reserved bits always read zero
// - Override-writable bits change only when override set
// - Parallel detection fault sets fault bit
// - Parallel detection fault bit latches high
// - Partner next page bit sets partner-able
// - Local next-page ability reads one
// - New received page sets page-received
// - Expansion read clears latched page-received
// - Partner auto-negotiation able after valid bursts
// - Transmit register field layout fixed
// - Next page bit copied to word
// - Next pages only if partner able
// - Message page bit drives word, resets one
// - Acknowledge-2 bit drives word
// - Transmit bit 14 reads zero, read-only
// - Transmit register resets to 0x2001
// - Toggle inverts per page, starts inverted
// - Code field copied into word
package anxr_pkg;
    // Byte addresses: printed index 6 and 7 are not multiples of four
    localparam logic [7:0] ANXR_IDX_EXP = 8'h06;
    localparam logic [7:0] ANXR_IDX_NPTX = 8'h07;
    localparam logic [7:0] ANXR_IDX_XCTL = 8'h10;
    localparam logic [11:0] ANXR_ADDR_EXP = {2'h0, ANXR_IDX_EXP, 2'h0};
    localparam logic [11:0] ANXR_ADDR_NPTX = {2'h0, ANXR_IDX_NPTX, 2'h0};
    localparam logic [11:0] ANXR_ADDR_XCTL = {2'h0, ANXR_IDX_XCTL, 2'h0};

    localparam int ANXR_EXP_PDF = 4;
    localparam int ANXR_EXP_LPNP = 3;
    localparam int ANXR_EXP_NPA = 2;
    localparam int ANXR_EXP_PR = 1;
    localparam int ANXR_EXP_LPAN = 0;
    localparam int ANXR_NP_NEXT = 15;
    localparam int ANXR_NP_MSG = 13;
    localparam int ANXR_NP_ACK2 = 12;
    localparam int ANXR_NP_TGL = 11;
    localparam int ANXR_XCTL_OVR = 15;
    localparam int ANXR_BASE_TGL = 11;

    localparam logic [15:0] ANXR_NPTX_RST = 16'h2001;
    localparam logic [15:0] ANXR_NPTX_WMASK = 16'hB7FF;
    localparam logic [15:0] ANXR_EXP_RESVD = 16'hFFE0;

    typedef struct packed {
        logic pdFault;
        logic pageRcvd;
        logic partnerNp;
        logic partnerAneg;
    } anxr_evt_t;

    typedef struct packed {
        logic nextPage;
        logic rsvd;
        logic msgPage;
        logic ack2;
        logic toggle;
        logic [10:0] code;
    } anxr_npword_t;
endpackage : anxr_pkg

// ==== rtl/anxr_regs.sv ====
// Auto-negotiation expansion status and next page transmit registers behind APB
`timescale 1ns/100ps
module anxr_regs import anxr_pkg::*; (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire anxr_evt_t linkEvt,
    input wire logic baseWordTgl,
    input wire logic pageSent,
    input wire logic pageLoad,
    output anxr_npword_t npWord,
    output logic npEnable
);
    typedef enum logic [1:0] {
        ANXR_IDLE = 2'b00,
        ANXR_DONE = 2'b01
    } anxr_bus_t;

    anxr_bus_t state_q, state_d;
    logic [15:0] nptx_q, nptx_d;
    logic override_q, override_d;
    logic partnerNp_q, partnerNp_d;
    logic partnerAneg_q, partnerAneg_d;
    logic pdPrev_q, pdPrev_d;
    logic tgl_q, tgl_d;
    logic firstPage_q, firstPage_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    anxr_npword_t npWord_q, npWord_d;
    logic npEnable_q, npEnable_d;
    logic pdLatched;
    logic prLatched;
    logic expRead;
    logic access;
    logic [15:0] expView;

    function automatic logic [15:0] anxr_merge(input logic [15:0] old, input logic [31:0] wd,
                                               input logic [3:0] be, input logic [15:0] msk);
        logic [15:0] lanes;
        lanes = {{8{be[1]}}, {8{be[0]}}} & msk;
        return (old & ~lanes) | (wd[15:0] & lanes);
    endfunction : anxr_merge

    assign access = psel && penable && (state_q == ANXR_IDLE);
    assign expRead = access && !pwrite && (paddr == ANXR_ADDR_EXP);

    // Fault and page-received are sticky until the expansion register is read
    anxr_latch_bit u_pdf (
        .mclk(mclk),
        .srst(srst),
        .setEvt(linkEvt.pdFault && !pdPrev_q),
        .readClr(expRead),
        .latched(pdLatched)
    );

    anxr_latch_bit u_prcv (
        .mclk(mclk),
        .srst(srst),
        .setEvt(linkEvt.pageRcvd),
        .readClr(expRead),
        .latched(prLatched)
    );

    always_comb begin
        expView = 16'h0000;
        expView[ANXR_EXP_PDF] = pdLatched || linkEvt.pdFault;
        expView[ANXR_EXP_LPNP] = partnerNp_q;
        expView[ANXR_EXP_NPA] = 1'b1;
        expView[ANXR_EXP_PR] = prLatched;
        expView[ANXR_EXP_LPAN] = partnerAneg_q;
        expView = expView & ~ANXR_EXP_RESVD;
    end

    always_comb begin
        state_d = state_q;
        nptx_d = nptx_q;
        override_d = override_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        case (state_q)
            ANXR_IDLE: begin
                if (access) begin
                    pready_d = 1'b1;
                    state_d = ANXR_DONE;
                    prdata_d = 32'h0000_0000;
                    case (paddr)
                        ANXR_ADDR_EXP: begin
                            // Bits above 4 are reserved and always read zero; no write path reaches this register, so writes have no effect
                            prdata_d = {16'h0000, expView};
                        end
                        ANXR_ADDR_NPTX: begin
                            prdata_d = {16'h0000, nptx_q[15:12], tgl_q, nptx_q[10:0]};
                            prdata_d[14] = 1'b0;
                        end
                        ANXR_ADDR_XCTL: begin
                            prdata_d[ANXR_XCTL_OVR] = override_q;
                        end
                        default: begin
                            pslverr_d = 1'b1;
                        end
                    endcase
                end
            end
            ANXR_DONE: begin
                state_d = ANXR_IDLE;
                // Writes land on the edge where the master sees pready, so an aborted access leaves no trace
                if (psel && penable && pwrite) begin
                    case (paddr)
                        ANXR_ADDR_NPTX: begin
                            if (override_q) begin
                                nptx_d = anxr_merge(nptx_q, pwdata, pstrb, ANXR_NPTX_WMASK);
                            end
                        end
                        ANXR_ADDR_XCTL: begin
                            if (pstrb[1]) begin
                                override_d = pwdata[ANXR_XCTL_OVR];
                            end
                        end
                        default: begin
                            nptx_d = nptx_q;
                        end
                    endcase
                end
            end
            default: begin
                state_d = ANXR_IDLE;
            end
        endcase
    end

    always_comb begin
        partnerNp_d = partnerNp_q;
        partnerAneg_d = partnerAneg_q || linkEvt.partnerAneg;
        pdPrev_d = linkEvt.pdFault;
        if (linkEvt.pageRcvd && linkEvt.partnerNp) begin
            partnerNp_d = 1'b1;
        end
        tgl_d = tgl_q;
        firstPage_d = firstPage_q;
        if (pageLoad) begin
            // A new negotiation restarts the toggle from the base word
            firstPage_d = 1'b1;
            tgl_d = !baseWordTgl;
        end else if (pageSent && npEnable_q) begin
            firstPage_d = 1'b0;
            tgl_d = !tgl_q;
        end
        npWord_d.nextPage = nptx_q[ANXR_NP_NEXT];
        npWord_d.rsvd = 1'b0;
        npWord_d.msgPage = nptx_q[ANXR_NP_MSG];
        npWord_d.ack2 = nptx_q[ANXR_NP_ACK2];
        npWord_d.toggle = tgl_q;
        npWord_d.code = nptx_q[10:0];
        npEnable_d = partnerNp_q;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= ANXR_IDLE;
            nptx_q <= ANXR_NPTX_RST;
            override_q <= 1'b0;
            partnerNp_q <= 1'b0;
            partnerAneg_q <= 1'b0;
            pdPrev_q <= 1'b0;
            tgl_q <= 1'b0;
            firstPage_q <= 1'b1;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            npWord_q <= '0;
            npEnable_q <= 1'b0;
        end else begin
            state_q <= state_d;
            nptx_q <= nptx_d;
            override_q <= override_d;
            partnerNp_q <= partnerNp_d;
            partnerAneg_q <= partnerAneg_d;
            pdPrev_q <= pdPrev_d;
            tgl_q <= tgl_d;
            firstPage_q <= firstPage_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            npWord_q <= npWord_d;
            npEnable_q <= npEnable_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign npWord = npWord_q;
    assign npEnable = npEnable_q;
endmodule : anxr_regs

// ==== verification/anxr_regs_chk.sv ====
// Checker for the expansion and next page transmit registers
`timescale 1ns/100ps
module anxr_regs_chk import anxr_pkg::*; (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [11:0] paddr,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire anxr_evt_t linkEvt,
    input wire logic baseWordTgl,
    input wire logic pageSent,
    input wire logic pageLoad,
    input wire anxr_npword_t npWord,
    input wire logic npEnable
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (srst);
    wire rdExp = pready && !pwrite && paddr == ANXR_ADDR_EXP;
    wire rdNp = pready && !pwrite && paddr == ANXR_ADDR_NPTX;
    a_exp_rsvd: assert property (rdExp |-> prdata[15:5] == 11'h000 && prdata[2])
        else $error("expansion read bad");
    a_nptx_rsvd: assert property (rdNp |-> !prdata[14])
        else $error("transmit bit 14 set");
    a_word_rsvd: assert property (!npWord.rsvd)
        else $error("word reserved bit set");
    a_pd_latch: assert property ($rose(linkEvt.pdFault) ##1 (!rdExp)[*6] ##1 rdExp |-> prdata[4])
        else $error("fault not latched");
    a_pr_set: assert property (linkEvt.pageRcvd ##1 (!rdExp)[*6] ##1 rdExp |-> prdata[1])
        else $error("page received not latched");
    a_pr_clear: assert property (!linkEvt.pageRcvd ##1 (rdExp && !linkEvt.pageRcvd) ##1
        (!linkEvt.pageRcvd && !rdExp)[*3] ##1 rdExp |-> !prdata[1])
        else $error("page received not cleared");
    a_aneg_seen: assert property (linkEvt.partnerAneg ##1 (!rdExp)[*6] ##1 rdExp |-> prdata[0])
        else $error("partner ability not shown");
    a_np_enable: assert property (linkEvt.pageRcvd && linkEvt.partnerNp |-> ##2 npEnable)
        else $error("next page enable missing");
    a_tgl_load: assert property (pageLoad && !pageSent ##1 !pageSent |=> npWord.toggle == !$past(baseWordTgl, 2))
        else $error("toggle load wrong");
    a_tgl_flip: assert property (pageSent && npEnable && !pageLoad ##1 !pageSent && !pageLoad
        |=> npWord.toggle != $past(npWord.toggle))
        else $error("toggle did not flip");
endmodule : anxr_regs_chk
bind anxr_regs anxr_regs_chk u_chk (.mclk(mclk), .srst(srst), .paddr(paddr), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .linkEvt(linkEvt), .baseWordTgl(baseWordTgl), .pageSent(pageSent), .pageLoad(pageLoad),
    .npWord(npWord), .npEnable(npEnable));

// ==== verification/anxr_sta.sv ====
// Management entity model driving the register bus
`timescale 1ns/100ps
module anxr_sta (
    input wire logic mclk,
    output logic [11:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready
);
    initial begin
        {paddr, psel, penable, pwrite, pwdata} = '0;
        pstrb = 4'h3;
    end
    task automatic xfer(input logic [11:0] a, input logic w, input logic [15:0] d, output logic [15:0] q);
        @(posedge mclk);
        paddr <= a;
        pwrite <= w;
        psel <= 1'h1;
        pwdata <= {16'h0000, d & 16'hBFFF}; // Reserved bit kept at its default
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        q = prdata[15:0];
        psel <= 1'h0;
        penable <= 1'h0;
        // A released bus must not look like a held one
        pwdata <= ~pwdata;
    endtask : xfer
endmodule : anxr_sta

// ==== verification/testbench.sv ====
// Self-checking bench for the expansion and next page transmit registers
`timescale 1ns/100ps
module testbench;
    import anxr_pkg::*;
    logic mclk = 1'h0;
    logic srst = 1'h1;
    logic [11:0] paddr;
    logic psel, penable, pwrite, pready, pslverr, npEnable, baseWordTgl, pageSent, pageLoad;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [15:0] q, d, npReg;
    anxr_evt_t linkEvt;
    anxr_npword_t npWord;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    logic tgl, npa, pr, pd, an;
    always #10 mclk = ~mclk;
    anxr_regs DUT (.mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .linkEvt(linkEvt),
        .baseWordTgl(baseWordTgl), .pageSent(pageSent), .pageLoad(pageLoad), .npWord(npWord), .npEnable(npEnable));
    anxr_sta sta (.mclk(mclk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready));
    task automatic cmp(input string n, input logic [15:0] s, input logic [15:0] x);
        checks++;
        if (s !== x) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, x, s);
        end
    endtask : cmp
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic rdx(input string n);
        sta.xfer(ANXR_ADDR_EXP, 1'h0, 16'h0000, q);
        cmp(n, q, {11'h000, pd, npa, 1'h1, pr, an});
        pd = 1'h0;
        pr = 1'h0;
    endtask : rdx
    task automatic rdn(input string n);
        sta.xfer(ANXR_ADDR_NPTX, 1'h0, 16'h0000, q);
        cmp(n, q, npReg | {4'h0, tgl, 11'h000});
        cmp("npWord", npWord, npReg | {4'h0, tgl, 11'h000});
        cmp("npEnable", {15'h0000, npEnable}, {15'h0000, npa});
    endtask : rdn
    // Event vector is {pdFault, pageRcvd, partnerNp, partnerAneg, pageSent, pageLoad}
    task automatic lk(input logic [5:0] v);
        @(posedge mclk);
        {linkEvt, pageSent, pageLoad} <= v;
        @(posedge mclk);
        {linkEvt, pageSent, pageLoad} <= 6'h00;
        repeat (3) @(posedge mclk);
    endtask : lk
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        {linkEvt, pageSent, pageLoad, baseWordTgl} = 7'h00;
        void'($urandom(93));
        npReg = 16'h2001;
        {tgl, npa, pr, pd, an} = 5'h00;
        repeat (6) @(posedge mclk);
        srst <= 1'h0;
        rdn("nptx reset");
        rdx("exp reset");
        sta.xfer(ANXR_ADDR_NPTX, 1'h1, 16'h1234, q);
        rdn("nptx locked");
        sta.xfer(12'hFFC, 1'h0, 16'h0000, q);
        cmp("unmapped", {15'h0000, pslverr}, 16'h0001);
        cmp("unmapped data", q, 16'h0000);
        sta.xfer(ANXR_ADDR_XCTL, 1'h1, 16'h8000, q);
        repeat (6) begin
            d = 16'($urandom);
            sta.xfer(ANXR_ADDR_NPTX, 1'h1, d, q);
            npReg = d & 16'hB7FF;
            rdn("nptx rw");
        end
        baseWordTgl <= 1'($urandom);
        lk(6'h01);
        tgl = ~baseWordTgl;
        rdn("toggle load");
        lk(6'h02);
        rdn("sent blocked");
        lk(6'h18);
        {npa, pr} = 2'h3;
        rdx("page rcvd");
        rdx("read clear");
        lk(6'h02);
        tgl = ~tgl;
        rdn("toggle flip");
        lk(6'h24);
        {pd, an} = 2'h3;
        rdx("fault");
        rdx("fault clear");
        summarize();
    end
endmodule : testbench
